// file: dv/mprs_host_model.sv
// host model: open-drain pulls on the ignition and restart lines
`timescale 1ns/1ps
`default_nettype none
module mprs_host_model
  import mprs_pkg::*;
(
  // pulls from the bench, 1 = pull low
  input wire logic pull_ign_i,
  input wire logic pull_rst_i,
  // device drive of each line
  input wire logic dev_ign_i,
  input wire logic dev_ign_oe_i,
  input wire logic dev_rst_i,
  input wire logic dev_rst_oe_i,
  // resolved line levels
  output logic ign_n_o,
  output logic rst_n_o
);
  // never driven high: a released line floats up to its pull-up
  assign ign_n_o = !(pull_ign_i || (dev_ign_oe_i && !dev_ign_i));
  assign rst_n_o = !(pull_rst_i || (dev_rst_oe_i && !dev_rst_i));
endmodule
`default_nettype wire

// file: dv/mprs_sequencer_sva.sv
// checker for the module power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module mprs_sequencer_sva
  import mprs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic module_ignite_n_i,
  input wire logic restart_n_i,
  input wire logic software_power_off_command_i,
  input wire logic module_ignite_n_oe_o,
  input wire logic restart_n_oe_o,
  input wire logic module_alive_rail_o,
  input wire logic operational_o,
  input wire logic [2:0] state_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  chk_pins_released: assert property (
    !module_ignite_n_oe_o && !restart_n_oe_o) else $error("line driven");
  chk_alive_off: assert property (
    state_o == MPRS_OFF |-> !module_alive_rail_o) else $error("alive while off");
  chk_alive_on: assert property (
    state_o inside {MPRS_BOOT, MPRS_ON} |-> module_alive_rail_o) else $error("dead while on");
  chk_power_up_wait: assert property (
    $fell(module_ignite_n_i) && state_o == MPRS_OFF |=> !operational_o [*8])
    else $error("up too early");
  chk_boot_not_ready: assert property (
    state_o == MPRS_BOOT |-> !operational_o) else $error("ready in boot");
  chk_ignite_no_off: assert property (
    state_o == MPRS_ON && restart_n_i && !software_power_off_command_i |=> state_o == MPRS_ON)
    else $error("left on state");
  chk_cmd_off: assert property (
    state_o == MPRS_ON && restart_n_i && software_power_off_command_i
    |=> state_o == MPRS_OFF && !module_alive_rail_o) else $error("no power off");
  chk_restart_low: assert property (
    (state_o == MPRS_RESTART && !module_ignite_n_i) ##1 state_o != MPRS_RESTART
    |-> state_o != MPRS_OFF) else $error("off after restart");
  chk_restart_high: assert property (
    state_o == MPRS_RESTART ##1 state_o == MPRS_OFF |-> !module_alive_rail_o)
    else $error("alive after restart");
endmodule
`default_nettype wire

// file: dv/mprs_sequencer_tb_top.sv
// testbench top for the module power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module mprs_sequencer_tb_top;
  import mprs_pkg::*;
  logic clock_i = 0, rst_i = 1, pi = 0, pr = 0, cmd = 0;
  logic ign_n, rst_n, io, ioe, ro, roe, alive, oper, clr;
  logic [2:0] st;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  logic seen = 0;
  // short counts keep the run brief; the boundary checks below derive from them
  localparam int IGN_T = 4;
  localparam int RST_T = 4;
  localparam int BOOT_T = 20;
  always #2.5 clock_i = ~clock_i;
  mprs_host_model mprs_host_model_i (.pull_ign_i(pi), .pull_rst_i(pr), .dev_ign_i(io),
    .dev_ign_oe_i(ioe), .dev_rst_i(ro), .dev_rst_oe_i(roe), .ign_n_o(ign_n), .rst_n_o(rst_n));
  mprs_sequencer #(.IGNITE_CYC(IGN_T), .RESTART_CYC(RST_T), .BOOT_CYC(BOOT_T))
    mprs_sequencer_i (
    .clock_i(clock_i), .rst_i(rst_i), .module_ignite_n_i(ign_n), .module_ignite_n_o(io),
    .module_ignite_n_oe_o(ioe), .restart_n_i(rst_n), .restart_n_o(ro), .restart_n_oe_o(roe),
    .software_power_off_command_i(cmd), .module_alive_rail_o(alive),
    .operational_o(oper), .clear_mem_o(clr), .state_o(st));
  // clr is sampled half a cycle away from the edge that launches it
  always @(negedge clock_i)
  begin
    cyc++;
    if (clr)
      seen = 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic run(input logic i, input logic r, input int n);
    pi = i;
    pr = r;
    repeat (n) @(negedge clock_i);
  endtask
  task automatic t_on();
    run(1, 0, 10);
    check(oper, 0);
    check(alive, 1);
    run(0, 0, BOOT_T - 10);
    check(oper, 0);
    run(0, 0, 10);
    check(st == MPRS_ON && oper, 1);
    $display("test power on done");
  endtask
  task automatic t_short();
    run(1, 0, IGN_T - 2);
    run(0, 0, 10);
    check(alive, 0);
    $display("test short ignition done");
  endtask
  task automatic t_ign_on();
    run(1, 0, 10);
    run(0, 0, 2);
    check(alive && oper, 1);
    $display("test ignition while on done");
  endtask
  task automatic t_rst_short();
    seen = 0;
    run(0, 1, RST_T - 2);
    run(0, 0, 3);
    check(st == MPRS_ON && alive && oper, 1);
    check(seen, 0);
    $display("test short restart done");
  endtask
  task automatic t_rst_low();
    seen = 0;
    run(1, 1, 6);
    run(1, 0, 3);
    check(seen, 1);
    check(alive, 1);
    check(oper, 0);
    run(1, 0, BOOT_T - 9);
    check(oper, 0);
    run(1, 0, 10);
    check(oper, 1);
    run(0, 0, 2);
    $display("test restart ignition low done");
  endtask
  task automatic t_rst_high();
    seen = 0;
    run(0, 1, 6);
    run(0, 0, 3);
    check(alive || oper, 0);
    check(st == MPRS_OFF && seen, 1);
    $display("test restart ignition high done");
  endtask
  task automatic t_swoff();
    cmd = 1;
    @(negedge clock_i);
    cmd = 0;
    run(0, 0, 2);
    check(alive || oper, 0);
    $display("test power off command done");
  endtask
  task automatic t_reset();
    rst_i = 1;
    run(0, 0, 2);
    check(alive || oper || clr, 0);
    check(st == MPRS_OFF, 1);
    rst_i = 0;
    run(0, 0, 2);
    check(alive || oper, 0);
    $display("test reset in run done");
  endtask
  initial
  begin
    repeat (3) @(negedge clock_i);
    rst_i = 0;
    run(0, 0, 2);
    check(alive, 0);
    t_short();
    t_on();
    t_ign_on();
    t_rst_short();
    t_rst_low();
    t_rst_high();
    t_on();
    t_reset();
    t_on();
    t_swoff();
    final_report();
  end
endmodule
bind mprs_sequencer mprs_sequencer_sva mprs_sequencer_sva_i (.clock_i, .rst_i,
  .module_ignite_n_i, .restart_n_i, .software_power_off_command_i, .module_ignite_n_oe_o,
  .restart_n_oe_o, .module_alive_rail_o, .operational_o, .state_o);
`default_nettype wire

// file: hdl/mprs_low_timer.sv
// low-level duration timer with falling-edge detect and saturating count
`timescale 1ns/1ps
`default_nettype none
module mprs_low_timer
  import mprs_pkg::*;
#(
  parameter int unsigned MIN_CYC = 100
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // line level (1 = high)
  input wire logic level_i,
  // results
  output logic fall_o,
  output logic long_enough_o
);

  typedef struct packed {
    logic prev;
    logic [CNT_W-1:0] cnt;
  } mprs_tmr_t;

  mprs_tmr_t s_reg;
  mprs_tmr_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.prev = level_i;
    if (level_i)
      s_next.cnt = '0;
    else if (s_reg.cnt < CNT_W'(MIN_CYC))
      s_next.cnt = s_reg.cnt + 1'b1;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      s_reg <= '{prev: 1'b1, cnt: '0};
    else
      s_reg <= s_next;
  end

  assign fall_o = s_reg.prev & ~level_i;
  assign long_enough_o = ~level_i & (s_reg.cnt >= CNT_W'(MIN_CYC));

endmodule
`default_nettype wire

// file: hdl/mprs_pkg.sv
// package: constants and carriers for the module power and reset sequencer
package mprs_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned IGNITE_MIN_MS = 25;
  localparam int unsigned RESTART_MIN_MS = 20;
  localparam int unsigned POWER_UP_MS = 2000;
  // least times round up; whole ms at 200 MHz divide exactly
  localparam int unsigned IGNITE_MIN_CYC = IGNITE_MIN_MS * CYC_PER_MS;
  localparam int unsigned RESTART_MIN_CYC = RESTART_MIN_MS * CYC_PER_MS;
  localparam longint unsigned POWER_UP_CYC = 64'(POWER_UP_MS) * 64'(CYC_PER_MS);
  localparam int CNT_W = 32;

  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [2:0] {
    MPRS_OFF = 3'b000,
    MPRS_IGNITE = 3'b001,
    MPRS_BOOT = 3'b010,
    MPRS_ON = 3'b011,
    MPRS_RESTART = 3'b100
  } mprs_state_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic alive_rail;
    logic operational;
    logic clear_mem;
  } mprs_status_t;

endpackage

// file: hdl/mprs_sequencer.sv
// module power-on and hard-reset sequencer, device side
`timescale 1ns/1ps
`default_nettype none
module mprs_sequencer
  import mprs_pkg::*;
#(
  parameter int unsigned IGNITE_CYC = IGNITE_MIN_CYC,
  parameter int unsigned RESTART_CYC = RESTART_MIN_CYC,
  parameter longint unsigned BOOT_CYC = POWER_UP_CYC
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // open-drain control pins: input level, low drive and its enable
  input wire logic module_ignite_n_i,
  output logic module_ignite_n_o,
  output logic module_ignite_n_oe_o,
  input wire logic restart_n_i,
  output logic restart_n_o,
  output logic restart_n_oe_o,
  // software power-off command from the serial command handler (one-cycle pulse)
  input wire logic software_power_off_command_i,
  // status
  output logic module_alive_rail_o,
  output logic operational_o,
  output logic clear_mem_o,
  output logic [2:0] state_o
);

  // ----------------------------------------
  // limits
  // ----------------------------------------
  // all timing is counted on clock_i from the sampled line level, so a glitch
  // shorter than one clock is either missed or seen as one whole cycle low, never filtered out
  // the pulse timers hold 32 bits, far more than the longest least pulse needs
  // a restart held low past its least time is acted on at once, not at its release

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // the pull-ups are outside this logic; the device never drives either line
  // driving a line high would fight the host's open-drain pull, so the enables stay off
  assign module_ignite_n_o = 1'b0;
  assign module_ignite_n_oe_o = 1'b0;
  assign restart_n_o = 1'b0;
  assign restart_n_oe_o = 1'b0;

  // ----------------------------------------
  // pulse timers
  // ----------------------------------------
  // both control lines share one timer design
  // index 0 is the ignition line, index 1 the restart line
  localparam int unsigned LINE_CNT = 2;

  logic [LINE_CNT-1:0] line_lvl;
  logic [LINE_CNT-1:0] line_fall;
  logic [LINE_CNT-1:0] line_valid;
  logic ign_fall;
  logic ign_valid;
  logic rst_fall;
  logic rst_valid;

  assign line_lvl = {restart_n_i, module_ignite_n_i};

  generate
    for (genvar g = 0; g < LINE_CNT; g++)
    begin : g_line
      // each edge detector resets to the pulled-up idle level, so no false fall
      mprs_low_timer #(.MIN_CYC(g == 0 ? IGNITE_CYC : RESTART_CYC)) u_tmr (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(line_lvl[g]),
        .fall_o(line_fall[g]),
        .long_enough_o(line_valid[g])
      );
    end
  endgenerate

  assign ign_fall = line_fall[0];
  assign ign_valid = line_valid[0];
  assign rst_fall = line_fall[1];
  assign rst_valid = line_valid[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  // boot_cnt is 64 bits wide although the full power-up period at the real
  // clock, 400000000 cycles, fits the 32-bit pulse counters; the cost is a wider
  // decrementer, traded for one counter that serves both power-up paths
  typedef struct packed {
    mprs_state_t st;
    logic [63:0] boot_cnt;
    mprs_status_t stat;
  } mprs_seq_t;

  mprs_seq_t s_reg;
  mprs_seq_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.stat.clear_mem = 1'b0;
    // the power-up counter runs down to zero in every state; only BOOT reads it
    if (s_reg.boot_cnt != 64'h0)
    begin
      s_next.boot_cnt = s_reg.boot_cnt - 64'h1;
    end
    case (s_reg.st)
      MPRS_OFF:
      begin
        // a restart pulse while off still wipes state; an ignition fall during it
        // is dropped, so the host releases restart before it asks for power
        if (!restart_n_i)
          s_next.stat.clear_mem = 1'b1;
        else if (ign_fall)
        begin
          s_next.st = MPRS_IGNITE;
          s_next.boot_cnt = BOOT_CYC;
        end
      end
      MPRS_IGNITE:
      begin
        // released before the least assertion time: refused, nothing else changes
        if (module_ignite_n_i)
        begin
          s_next.st = MPRS_OFF;
        end
        else if (ign_valid)
        begin
          s_next.st = MPRS_BOOT;
          s_next.stat.alive_rail = 1'b1;
        end
      end
      MPRS_BOOT, MPRS_ON:
      begin
        // ignition is not looked at here, so asserting it again cannot switch off;
        // a restart edge wins over a power-off command in the same cycle
        if (rst_fall)
        begin
          s_next.st = MPRS_RESTART;
        end
        else if (software_power_off_command_i)
        begin
          s_next.st = MPRS_OFF;
          s_next.stat.alive_rail = 1'b0;
          s_next.stat.operational = 1'b0;
        end
        else if (s_reg.st == MPRS_BOOT && s_reg.boot_cnt == 64'h0)
        begin
          s_next.st = MPRS_ON;
          s_next.stat.operational = 1'b1;
        end
      end
      MPRS_RESTART:
      begin
        // a short pulse is ignored and the module keeps running as it was
        if (restart_n_i)
        begin
          s_next.st = s_reg.stat.operational ? MPRS_ON : MPRS_BOOT;
        end
        else if (rst_valid)
        begin
          // the boot count starts at the restart fall, so the pulse time is taken off
          s_next.stat.clear_mem = 1'b1;
          s_next.stat.operational = 1'b0;
          if (!module_ignite_n_i)
          begin
            s_next.st = MPRS_BOOT;
            s_next.boot_cnt = BOOT_CYC - 64'(RESTART_CYC);
          end
          else
          begin
            s_next.st = MPRS_OFF;
            s_next.stat.alive_rail = 1'b0;
          end
        end
      end
      default:
      begin
        // an illegal state code falls back to off with every flag cleared
        s_next.st = MPRS_OFF;
        s_next.boot_cnt = 64'h0;
        s_next.stat = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      s_reg <= '{st: MPRS_OFF, boot_cnt: 64'h0, stat: '0};
    else
      s_reg <= s_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every status output comes straight from a flip-flop, so the host never sees
  // a glitch on the alive rail while the state word changes
  assign module_alive_rail_o = s_reg.stat.alive_rail;
  assign operational_o = s_reg.stat.operational;
  assign clear_mem_o = s_reg.stat.clear_mem;
  assign state_o = s_reg.st;

endmodule
`default_nettype wire
